/* logic/tcc_consts.vh */
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define TCC_IDX_CH0_HI     8'h27
`define TCC_IDX_CH0_LO     8'h28
`define TCC_IDX_CH1_HI     8'h2A
`define TCC_IDX_CH1_LO     8'h2B
`define TCC_IDX_CH2_HI     8'h2D
`define TCC_IDX_CH2_LO     8'h2E
`define TCC_IDX_CH3_HI     8'h30
`define TCC_IDX_CH3_LO     8'h31
// Each control register sits one index below its channel's high byte.
`define TCC_CTL_GAP        8'h01

// Control register field positions.
`define TCC_BIT_FLAG       7
`define TCC_BIT_MSB        5
`define TCC_BIT_MSA        4
`define TCC_BIT_ELSH       3
`define TCC_BIT_ELSL       2
`define TCC_BIT_TOV        1
`define TCC_BIT_MAX        0

// Edge/level field codes.
`define TCC_ELS_OFF        2'h0
`define TCC_ELS_TOGGLE     2'h1
`define TCC_ELS_CLEAR      2'h2
`define TCC_ELS_SET        2'h3

// Reset values and bus answers.
`define TCC_PIN_RST        4'hF
`define TCC_PORT_RST       4'hF
`define TCC_RESP_OKAY      2'h0
`define TCC_RESP_SLVERR    2'h2

`endif

/* logic/tcc_top.v */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`include "tcc_consts.vh"

module tcc_top (
  // Clock, reset and freeze.
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        ce_i,
  // Shared counter time base.
  input  wire [15:0] counter_i,
  input  wire        cnt_tick_i,
  input  wire        overflow_i,
  // Channel pins.
  input  wire [3:0]  pin_i,
  output wire [3:0]  pin_o,
  output wire [3:0]  pin_oe_o,
  output wire [3:0]  port_ctrl_o,
  output wire [3:0]  chan_flag_o,
  // AXI4-Lite write channels.
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////

  reg  [3:0]  msb_reg;
  reg  [3:0]  msa_reg;
  reg  [3:0]  elsh_reg;
  reg  [3:0]  elsl_reg;
  reg  [3:0]  tov_reg;
  reg  [3:0]  max_reg;
  reg  [3:0]  maxe_reg;
  reg  [3:0]  flag_reg;
  reg  [3:0]  arm_reg;
  reg  [3:0]  rdlk_reg;
  reg  [3:0]  wrlk_reg;
  reg  [3:0]  pin_reg;
  reg  [3:0]  oe_reg;
  reg  [3:0]  port_reg;
  reg  [15:0] val_reg [0:3];
  reg  [3:0]  s1_reg;
  reg  [3:0]  s2_reg;
  reg  [3:0]  s3_reg;
  reg  [3:0]  filt_reg;
  reg  [1:0]  asel_reg;
  reg  [1:0]  pend_reg;
  reg  [1:0]  psel_reg;

  reg         awv_reg;
  reg  [7:0]  awidx_reg;
  reg         wv_reg;
  reg  [7:0]  wdat_reg;
  reg         wstb_reg;
  reg         bvalid_reg;
  reg  [1:0]  bresp_reg;
  reg         rvalid_reg;
  reg  [1:0]  rresp_reg;
  reg  [7:0]  rdata_reg;

  reg  [3:0]  dis;
  reg  [3:0]  en;
  reg  [3:0]  cap;
  reg  [3:0]  oc;
  reg  [3:0]  match;
  reg  [3:0]  cap_ev;
  reg  [3:0]  filt_next;
  reg  [1:0]  els;
  reg  [1:0]  src;
  reg         rd_hit;
  reg  [7:0]  rd_data;
  reg         wr_hit;
  integer     i;

  wire        wr_go = awv_reg & wv_reg & ~bvalid_reg;
  wire        rd_go = s_axi_arvalid & ~rvalid_reg;
  wire [7:0]  ridx  = s_axi_araddr[9:2];

  ////////////////////////////////////////////////////////////////////////////

  function [7:0] hi_idx;
    input [1:0] ch;
    begin
      case (ch)
        2'h0: hi_idx = `TCC_IDX_CH0_HI;
        2'h1: hi_idx = `TCC_IDX_CH1_HI;
        2'h2: hi_idx = `TCC_IDX_CH2_HI;
        default: hi_idx = `TCC_IDX_CH3_HI;
      endcase
    end
  endfunction

  function [7:0] lo_idx;
    input [1:0] ch;
    begin
      case (ch)
        2'h0: lo_idx = `TCC_IDX_CH0_LO;
        2'h1: lo_idx = `TCC_IDX_CH1_LO;
        2'h2: lo_idx = `TCC_IDX_CH2_LO;
        default: lo_idx = `TCC_IDX_CH3_LO;
      endcase
    end
  endfunction

  function [7:0] ctl_idx;
    input [1:0] ch;
    begin
      ctl_idx = hi_idx(ch) - `TCC_CTL_GAP;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // Channel decode, compare source, edge and match detection.
  always @* begin : chan_decode
    integer i;
    i   = 0;
    els = `TCC_ELS_OFF;
    src = 2'h0;
    for (i = 0; i < 4; i = i + 1) begin
      dis[i] = (i == 1 && msb_reg[0]) || (i == 3 && msb_reg[2]);
      els = dis[i] ? `TCC_ELS_OFF : {elsh_reg[i], elsl_reg[i]};
      en[i] = (els != `TCC_ELS_OFF);
      cap[i] = en[i] & ~msa_reg[i] & ~msb_reg[i];
      oc[i] = en[i] & (msa_reg[i] | msb_reg[i]);
      // A buffered pair compares against whichever register is active.
      src = msb_reg[i] ? {i[1], asel_reg[i[1]]} : i[1:0];
      match[i] = oc[i] & cnt_tick_i & ~wrlk_reg[src] &
                 (counter_i == val_reg[src]);
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
      case (els)
        `TCC_ELS_TOGGLE: cap_ev[i] = filt_next[i] & ~filt_reg[i];
        `TCC_ELS_CLEAR:  cap_ev[i] = ~filt_next[i] & filt_reg[i];
        `TCC_ELS_SET:    cap_ev[i] = filt_next[i] ^ filt_reg[i];
        default:         cap_ev[i] = 1'b0;
      endcase
      cap_ev[i] = cap_ev[i] & cap[i];
    end
  end

  // Read decode; a disabled channel's control register reads as zero.
  always @* begin : bus_decode
    integer i;
    i       = 0;
    rd_hit  = 1'b0;
    rd_data = 8'h00;
    wr_hit  = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (awidx_reg == ctl_idx(i[1:0]) || awidx_reg == hi_idx(i[1:0]) ||
          awidx_reg == lo_idx(i[1:0])) begin
        wr_hit = 1'b1;
      end
      if (ridx == ctl_idx(i[1:0])) begin
        rd_hit = 1'b1;
        if (!dis[i]) begin
          rd_data[`TCC_BIT_FLAG] = flag_reg[i];
          rd_data[`TCC_BIT_MSB]  = msb_reg[i];
          rd_data[`TCC_BIT_MSA]  = msa_reg[i];
          rd_data[`TCC_BIT_ELSH] = elsh_reg[i];
          rd_data[`TCC_BIT_ELSL] = elsl_reg[i];
          rd_data[`TCC_BIT_TOV]  = tov_reg[i];
          rd_data[`TCC_BIT_MAX]  = max_reg[i];
        end
      end
      if (ridx == hi_idx(i[1:0])) begin
        rd_hit  = 1'b1;
        rd_data = val_reg[i][15:8];
      end
      if (ridx == lo_idx(i[1:0])) begin
        rd_hit  = 1'b1;
        rd_data = val_reg[i][7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Channel state and bus side effects. The value registers carry no reset.
  always @(posedge clk_i) begin
    if (srst_i) begin
      msb_reg    <= 4'h0;
      msa_reg    <= 4'h0;
      elsh_reg   <= 4'h0;
      elsl_reg   <= 4'h0;
      tov_reg    <= 4'h0;
      max_reg    <= 4'h0;
      maxe_reg   <= 4'h0;
      flag_reg   <= 4'h0;
      arm_reg    <= 4'h0;
      rdlk_reg   <= 4'h0;
      wrlk_reg   <= 4'h0;
      pin_reg    <= `TCC_PIN_RST;
      oe_reg     <= 4'h0;
      port_reg   <= `TCC_PORT_RST;
      s1_reg     <= 4'h0;
      s2_reg     <= 4'h0;
      s3_reg     <= 4'h0;
      filt_reg   <= 4'h0;
      asel_reg   <= 2'h0;
      pend_reg   <= 2'h0;
      psel_reg   <= 2'h0;
      awv_reg    <= 1'b0;
      awidx_reg  <= 8'h00;
      wv_reg     <= 1'b0;
      wdat_reg   <= 8'h00;
      wstb_reg   <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= `TCC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= `TCC_RESP_OKAY;
      rdata_reg  <= 8'h00;
    end else if (ce_i) begin
      // Pin input passes three flops; the filter waits for two to agree.
      s1_reg   <= pin_i;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
      oe_reg   <= oc;
      port_reg <= ~en;

      // Write address and data are taken independently.
      if (s_axi_awvalid && !awv_reg) begin
        awv_reg   <= 1'b1;
        awidx_reg <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && !wv_reg) begin
        wv_reg   <= 1'b1;
        wdat_reg <= s_axi_wdata[7:0];
        wstb_reg <= s_axi_wstrb[0];
      end
      if (s_axi_bready && bvalid_reg) begin
        bvalid_reg <= 1'b0;
      end
      if (s_axi_rready && rvalid_reg) begin
        rvalid_reg <= 1'b0;
      end
      if (wr_go) begin
        awv_reg    <= 1'b0;
        wv_reg     <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= rd_hit ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        rdata_reg  <= rd_data;
      end

      for (i = 0; i < 4; i = i + 1) begin
        // Register writes.
        if (wr_go && wstb_reg) begin
          if (awidx_reg == ctl_idx(i[1:0]) && !dis[i]) begin
            if (i == 0 || i == 2) begin
              msb_reg[i] <= wdat_reg[`TCC_BIT_MSB];
            end
            msa_reg[i]  <= wdat_reg[`TCC_BIT_MSA];
            elsh_reg[i] <= wdat_reg[`TCC_BIT_ELSH];
            elsl_reg[i] <= wdat_reg[`TCC_BIT_ELSL];
            tov_reg[i]  <= wdat_reg[`TCC_BIT_TOV];
            max_reg[i]  <= wdat_reg[`TCC_BIT_MAX];
            if (!wdat_reg[`TCC_BIT_FLAG] && arm_reg[i]) begin
              flag_reg[i] <= 1'b0;
              arm_reg[i]  <= 1'b0;
            end
          end
          if (awidx_reg == hi_idx(i[1:0])) begin
            val_reg[i][15:8] <= wdat_reg;
            wrlk_reg[i]      <= 1'b1;
          end
          if (awidx_reg == lo_idx(i[1:0])) begin
            val_reg[i][7:0] <= wdat_reg;
            wrlk_reg[i]     <= 1'b0;
            if (msb_reg[{i[1], 1'b0}]) begin
              pend_reg[i[1]] <= 1'b1;
              psel_reg[i[1]] <= i[0];
            end
          end
        end

        // Register reads with side effects.
        if (rd_go) begin
          if (ridx == ctl_idx(i[1:0]) && flag_reg[i]) begin
            arm_reg[i] <= 1'b1;
          end
          if (ridx == hi_idx(i[1:0])) begin
            rdlk_reg[i] <= 1'b1;
          end
          if (ridx == lo_idx(i[1:0])) begin
            rdlk_reg[i] <= 1'b0;
          end
        end

        // Capture copies the counter; a pending high-byte read holds it off.
        if (cap_ev[i] && !rdlk_reg[i]) begin
          val_reg[i] <= counter_i;
        end

        // A new event sets the flag and disarms any clear in progress.
        if ((cap_ev[i] || match[i]) && !rdlk_reg[i]) begin
          flag_reg[i] <= 1'b1;
          arm_reg[i]  <= 1'b0;
        end

        // Full duty follows the bit only from a period boundary.
        if (overflow_i) begin
          maxe_reg[i] <= max_reg[i];
        end

        // Pin level.
        if (!en[i]) begin
          pin_reg[i] <= ~msa_reg[i];
        end else if (oc[i]) begin
          if (maxe_reg[i] && !tov_reg[i]) begin
            // At full duty hold the pin high, or low for the set-on-compare code.
            pin_reg[i] <= ({elsh_reg[i], elsl_reg[i]} != `TCC_ELS_SET);
          end else if (tov_reg[i] && overflow_i) begin
            if (!rdlk_reg[i]) begin
              pin_reg[i] <= ~pin_reg[i];
            end
          end else if (match[i] && !rdlk_reg[i]) begin
            case ({elsh_reg[i], elsl_reg[i]})
              `TCC_ELS_TOGGLE: pin_reg[i] <= ~pin_reg[i];
              `TCC_ELS_CLEAR:  pin_reg[i] <= 1'b0;
              `TCC_ELS_SET:    pin_reg[i] <= 1'b1;
              default:         pin_reg[i] <= pin_reg[i];
            endcase
          end
        end
      end

      // The last written register of a buffered pair goes live at overflow.
      for (i = 0; i < 2; i = i + 1) begin
        if (overflow_i && pend_reg[i]) begin
          asel_reg[i] <= psel_reg[i];
          pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign pin_o         = pin_reg;
  assign pin_oe_o      = oe_reg;
  assign port_ctrl_o   = port_reg;
  assign chan_flag_o   = flag_reg;
  assign s_axi_awready = ~awv_reg;
  assign s_axi_wready  = ~wv_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {24'h00_0000, rdata_reg};

endmodule // tcc_top

/* verification/tcc_checker_asserts.sv */
`timescale 1ns/10ps
module tcc_checker (
  // Clock, reset and time base.
  input wire        clk_i,
  input wire        srst_i,
  input wire        ce_i,
  input wire        cnt_tick_i,
  input wire        overflow_i,
  // Pins and flags.
  input wire [3:0]  pin_o,
  input wire [3:0]  pin_oe_o,
  input wire [3:0]  port_ctrl_o,
  input wire [3:0]  chan_flag_o,
  // Bus answers.
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_rst;
    disable iff (1'b0) srst_i |=> pin_o == 4'hF && pin_oe_o == 4'h0
      && port_ctrl_o == 4'hF && chan_flag_o == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_excl;
    (pin_oe_o & port_ctrl_o) == 4'h0;
  endproperty
  a_excl: assert property (p_excl) else $error("pin owned twice");
  // A driven pin may only move after a tick or an overflow.
  property p_pin;
    ((pin_o ^ $past(pin_o)) & pin_oe_o & $past(pin_oe_o)) != 4'h0
      |-> $past(cnt_tick_i | overflow_i) || $past(cnt_tick_i | overflow_i, 2);
  endproperty
  a_pin: assert property (p_pin) else $error("pin moved uncaused");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_arrdy;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_arrdy: assert property (p_arrdy) else $error("read accept wrong");
  property p_rwid;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rwid: assert property (p_rwid) else $error("read data too wide");
  property p_freeze;
    !ce_i |=> $stable(pin_o) && $stable(chan_flag_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while frozen");
endmodule // tcc_checker

bind tcc_top tcc_checker tcc_checker_inst (.clk_i, .srst_i, .ce_i,
  .cnt_tick_i, .overflow_i, .pin_o, .pin_oe_o, .port_ctrl_o, .chan_flag_o,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

/* verification/tcc_pin_src.sv */
`timescale 1ns/10ps
module tcc_pin_src (
  // Clock.
  input  wire       clk_i,
  // Levels of the outside sources.
  output reg  [3:0] lvl_o
);
  initial lvl_o = 4'h0;
  // Every change is held long enough for capture setup.
  task drive(input [1:0] ch, input v);
    begin
      @(posedge clk_i);
      lvl_o[ch] <= v;
      repeat (8) @(posedge clk_i);
    end
  endtask
endmodule // tcc_pin_src

/* verification/test_timer_channel_capture_compare.sv */
`timescale 1ns/10ps
module test_timer_channel_capture_compare;
  reg         clk_i, srst_i, cnt_tick_i, overflow_i;
  reg  [15:0] counter_i;
  reg  [9:0]  aw_a, ar_a;
  reg  [31:0] w_d;
  reg         aw_v, w_v, b_r, ar_v, r_r;
  reg         ce;
  reg  [1:0]  wresp;
  wire [3:0]  po, poe, pc, fl, src;
  wire        awr, wrr, bv, arr, rv;
  wire [1:0]  br, rr;
  wire [31:0] rdat;
  wire [3:0]  pin_w = (poe & po) | (~poe & src);
  integer     mismatches, checks;

  tcc_top tcc_top_inst (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce),
    .counter_i(counter_i), .cnt_tick_i(cnt_tick_i), .overflow_i(overflow_i),
    .pin_i(pin_w), .pin_o(po), .pin_oe_o(poe), .port_ctrl_o(pc),
    .chan_flag_o(fl), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(awr), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(w_v), .s_axi_wready(wrr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(b_r), .s_axi_araddr(ar_a),
    .s_axi_arvalid(ar_v), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(r_r));
  tcc_pin_src tcc_pin_src_inst (.clk_i(clk_i), .lvl_o(src));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////
  task final_report;
    begin
      if (mismatches == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task tmo;
    begin
      mismatches = mismatches + 1;
      $display("ERROR %0t bus wait ran out", $time);
      final_report;
    end
  endtask
  // Ready is sampled at the falling edge, so it equals the rising-edge value.
  task wr(input [7:0] i, input [7:0] d);
    integer n;
    reg a, w, b;
    begin
      n = 0;
      b = 1'b0;
      @(posedge clk_i);
      aw_a <= {i, 2'b00};
      w_d <= {24'h00_0000, d};
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      while (!b) begin
        @(negedge clk_i);
        a = aw_v & awr;
        w = w_v & wrr;
        b = bv;
        if (bv) wresp = br;
        @(posedge clk_i);
        if (a) aw_v <= 1'b0;
        if (w) w_v <= 1'b0;
        if (b) b_r <= 1'b0;
        n = n + 1;
        if (n > 50) tmo;
      end
      // One more edge, so that callers see what the write has launched.
      @(posedge clk_i);
    end
  endtask
  task rd(input [7:0] i, output [31:0] d, output [1:0] r);
    integer n;
    reg a, v;
    begin
      n = 0;
      v = 1'b0;
      @(posedge clk_i);
      ar_a <= {i, 2'b00};
      ar_v <= 1'b1;
      r_r <= 1'b1;
      while (!v) begin
        @(negedge clk_i);
        a = ar_v & arr;
        v = rv;
        d = rdat;
        r = rr;
        @(posedge clk_i);
        if (a) ar_v <= 1'b0;
        if (v) r_r <= 1'b0;
        n = n + 1;
        if (n > 50) tmo;
      end
      @(posedge clk_i);
    end
  endtask
  task tk(input [15:0] c, input t, input o);
    begin
      @(posedge clk_i);
      counter_i <= c;
      cnt_tick_i <= t;
      overflow_i <= o;
      @(posedge clk_i);
      cnt_tick_i <= 1'b0;
      overflow_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  reg [31:0] d;
  reg [1:0]  r;
  reg        p;
  integer    e;
  task t_rst;
    begin
      chk({po, poe, pc, fl}, 16'hF0F0);
      rd(8'h26, d, r);
      chk(d, 32'h0000_0000);
      rd(8'h00, d, r);
      chk(r, 2'h2);
      wr(8'h00, 8'h00);
      chk(wresp, 2'h2);
    end
  endtask
  task t_pre;
    begin
      wr(8'h29, 8'h10);
      chk({pc[1], po[1]}, 2'h2);
      chk(wresp, 2'h0);
      wr(8'h29, 8'h00);
      chk({pc[1], po[1]}, 2'h3);
    end
  endtask
  // Mode changes happen only while no tick is offered, as with a held counter.
  task t_cmp;
    begin
      wr(8'h27, 8'h00);
      wr(8'h28, 8'h10);
      for (e = 1; e < 4; e = e + 1) begin
        wr(8'h26, {4'h1, e[1:0], 2'b00});
        p = po[0];
        tk(16'h0010, 1'b1, 1'b0);
        chk(po[0], e == 1 ? !p : e == 3);
      end
      tk(16'h0011, 1'b1, 1'b0);
      chk({po[0], fl[0], poe[0], pc[0]}, 4'hE);
    end
  endtask
  task t_tov;
    begin
      wr(8'h26, 8'h1A);
      tk(16'h0010, 1'b1, 1'b0);
      chk(po[0], 1'b0);
      tk(16'h0005, 1'b0, 1'b1);
      chk(po[0], 1'b1);
      tk(16'h0010, 1'b1, 1'b0);
      tk(16'h0010, 1'b1, 1'b1);
      chk(po[0], 1'b1);
    end
  endtask
  task t_lock;
    begin
      wr(8'h26, 8'h14);
      wr(8'h27, 8'h00);
      p = po[0];
      tk(16'h0010, 1'b1, 1'b0);
      chk(po[0], p);
      wr(8'h28, 8'h10);
      tk(16'h0010, 1'b1, 1'b0);
      chk(po[0], !p);
      rd(8'h27, d, r);
      tk(16'h0010, 1'b1, 1'b0);
      chk(po[0], !p);
      rd(8'h28, d, r);
      chk(d, 32'h0000_0010);
      tk(16'h0010, 1'b1, 1'b0);
      chk(po[0], p);
    end
  endtask
  task t_cap;
    begin
      for (e = 1; e < 4; e = e + 1) begin
        wr(8'h2C, {4'h0, e[1:0], 2'b00});
        counter_i <= {12'h12A, e[3:0]};
        tcc_pin_src_inst.drive(2'd2, e[0]);
        rd(8'h2D, d, r);
        chk(d, 32'h0000_0012);
        rd(8'h2E, d, r);
        chk(d, {28'h000_000A, e[3:0]});
      end
      chk(fl[2], 1'b1);
      rd(8'h2C, d, r);
      wr(8'h2C, 8'h0C);
      chk(fl[2], 1'b0);
      rd(8'h2D, d, r);
      counter_i <= 16'h3456;
      tcc_pin_src_inst.drive(2'd2, 1'b0);
      chk(fl[2], 1'b0);
      rd(8'h2E, d, r);
      chk(d, 32'h0000_00A3);
      wr(8'h2C, 8'h08);
      counter_i <= 16'h789A;
      tcc_pin_src_inst.drive(2'd2, 1'b1);
      rd(8'h2E, d, r);
      chk(d, 32'h0000_00A3);
    end
  endtask
  task t_buf;
    begin
      wr(8'h29, 8'h24);
      rd(8'h29, d, r);
      chk(d, 32'h0000_0004);
      wr(8'h26, 8'h24);
      chk({pc[1], poe[0]}, 2'h3);
      wr(8'h29, 8'h14);
      rd(8'h29, d, r);
      chk(d, 32'h0000_0000);
      wr(8'h2F, 8'h14);
      chk(pc[3], 1'b0);
      wr(8'h2C, 8'h24);
      chk(pc[3], 1'b1);
    end
  endtask
  // The odd register of the pair goes live only at the next overflow.
  task t_alt;
    begin
      wr(8'h2A, 8'h00);
      wr(8'h2B, 8'h20);
      p = po[0];
      tk(16'h0020, 1'b1, 1'b0);
      chk(po[0], p);
      tk(16'h0005, 1'b0, 1'b1);
      tk(16'h0020, 1'b1, 1'b0);
      chk(po[0], !p);
      tk(16'h0010, 1'b1, 1'b0);
      chk(po[0], !p);
    end
  endtask
  task t_max;
    begin
      wr(8'h26, 8'h25);
      p = po[0];
      tk(16'h0020, 1'b1, 1'b0);
      chk(po[0], !p);
      tk(16'h0005, 1'b0, 1'b1);
      chk(po[0], 1'b1);
      tk(16'h0020, 1'b1, 1'b0);
      chk(po[0], 1'b1);
      wr(8'h26, 8'h24);
      tk(16'h0020, 1'b1, 1'b0);
      chk(po[0], 1'b1);
      tk(16'h0005, 1'b0, 1'b1);
      tk(16'h0020, 1'b1, 1'b0);
      chk(po[0], 1'b0);
    end
  endtask
  task t_frz;
    begin
      ce <= 1'b0;
      p = po[0];
      tk(16'h0020, 1'b1, 1'b0);
      chk(po[0], p);
      ce <= 1'b1;
      tk(16'h0020, 1'b1, 1'b0);
      chk(po[0], !p);
    end
  endtask
  task t_rrst;
    begin
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      chk({po, poe, pc, fl}, 16'hF0F0);
      rd(8'h26, d, r);
      chk(d, 32'h0000_0000);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    mismatches = 0;
    checks = 0;
    {ce, srst_i, cnt_tick_i, overflow_i, counter_i} = 20'hC_0000;
    {aw_a, ar_a, w_d, aw_v, w_v, b_r, ar_v, r_r} = 57'h0;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    t_rst;
    t_pre;
    t_cmp;
    t_tov;
    t_lock;
    t_cap;
    t_buf;
    t_alt;
    t_max;
    t_frz;
    t_rrst;
    final_report;
  end
endmodule // test_timer_channel_capture_compare
